// ---- logic/tudc_pkg.sv ----
/*
   Package for the timed up/down counter: widths, reset values and tick timing.
   Assumes a 50 MHz system clock.
*/
package tudc_pkg;
   localparam int          TUDC_W          = 16;
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          TASK_INTERVAL_MS = 20;
   localparam int          TASK_TICK_CYC   = (TASK_INTERVAL_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [15:0] ACC_RST         = 16'h0000;
   localparam logic [15:0] POS_LIMIT       = 16'h7FFF;
   localparam logic [15:0] NEG_LIMIT       = 16'h8001;
   localparam logic [1:0]  DIR_UP          = 2'h1;
   localparam logic [1:0]  DIR_DOWN        = 2'h3;
   localparam logic [1:0]  DIR_NONE        = 2'h0;
   localparam logic [15:0] PERIOD_RST      = 16'h0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } tudc_state_t;
endpackage

// ---- logic/tudc_tick.sv ----
/*
   Task interval tick generator: one-cycle pulse every TICK_CYC enabled cycles.
   Assumes a synchronous clock enable from the same domain.
*/
`timescale 1ns/10ps
module tudc_tick
   import tudc_pkg::*;
#(
   parameter int TICK_CYC = TASK_TICK_CYC
) (
   // Clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_sys_rst,
   input  wire logic i_ce,
   // Tick
   output logic      o_tick
);
   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } tudc_tick_st_t;

   tudc_tick_st_t st_ff;
   tudc_tick_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (st_ff.cnt >= 32'(TICK_CYC - 1)) begin
         nxt_st.cnt = 32'h0000_0000;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_ff <= '0;
      end else if (i_ce) begin
         st_ff <= nxt_st;
      end
   end

   assign o_tick = st_ff.tick;
endmodule

// ---- logic/tudc_sync.sv ----
/*
   Two flip-flop synchroniser for a group of level inputs.
   Assumes inputs may come from outside the clock domain.
*/
`timescale 1ns/10ps
module tudc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_sys_rst,
   input  wire logic         i_ce,
   // Data
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tudc_sync_st_t;

   tudc_sync_st_t st_ff;
   tudc_sync_st_t nxt_st;

   always_comb begin
      nxt_st.s1 = i_d;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_ff <= '0;
      end else if (i_ce) begin
         st_ff <= nxt_st;
      end
   end

   assign o_q = st_ff.s2;
endmodule

// ---- logic/tudc_top.sv ----
/*
   Timed up/down counter: signed 16-bit accumulator stepped once per period,
   evaluated once per 20 ms task interval, with load, limits and direction.
   Assumes control pins are asynchronous levels; setting pins are held stable.
*/
// Summary of operation
// - While load is high the accumulator takes the preset value.
// - Select low uses step_a, select high uses step_b.
// - Period elapsed and increment high: add step, direction becomes 1.
// - Period elapsed and decrement high: subtract step, direction becomes -1.
// - Period setting is unsigned milliseconds, resolved in 20 ms task ticks.
// - Above upper limit: clamp to it, high flag set, low flag cleared.
// - Below lower limit: clamp to it, low flag set, high flag cleared.
// - Strictly between limits: both limit flags false.
// - Direction is -1 down, 1 up, 0 when the accumulator does not change.
// - Output is a signed 16-bit value within plus or minus 32767.
`timescale 1ns/10ps
module tudc_top
   import tudc_pkg::*;
#(
   parameter int TICK_CYC = TASK_TICK_CYC
) (
   // Clock, reset, enable
   input  wire logic               i_clk_sys,
   input  wire logic               i_sys_rst,
   input  wire logic               i_ce,
   // Control pins
   input  wire logic               i_load,
   input  wire logic               i_inc,
   input  wire logic               i_dec,
   input  wire logic               i_select,
   // Settings
   input  wire logic signed [15:0] i_preset,
   input  wire logic signed [15:0] i_upper,
   input  wire logic signed [15:0] i_lower,
   input  wire logic signed [15:0] i_step_a,
   input  wire logic signed [15:0] i_step_b,
   input  wire logic        [15:0] i_period_ms,
   // Results
   output logic signed      [15:0] o_count,
   output logic signed      [1:0]  o_dir,
   output logic                    o_at_high_limit,
   output logic                    o_at_low_limit
);
   typedef struct packed {
      tudc_state_t        state;
      logic signed [15:0] acc;
      logic        [1:0]  dir;
      logic               hi;
      logic               lo;
      logic        [15:0] elapsed_ms;
   } tudc_top_st_t;

   tudc_top_st_t st_ff;
   tudc_top_st_t nxt_st;
   logic         tick;
   logic [3:0]   ctl_s;

   tudc_tick #(
      .TICK_CYC (TICK_CYC)
   ) u_tick (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .o_tick    (tick)
   );

   tudc_sync #(
      .W (4)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .i_d       ({i_load, i_inc, i_dec, i_select}),
      .o_q       (ctl_s)
   );

   logic signed [17:0] sum;
   logic signed [15:0] step;
   logic               due;
   logic               moved;
   logic signed [15:0] clamped;

   always_comb begin
      nxt_st = st_ff;
      sum = 18'(st_ff.acc);
      step = ctl_s[0] ? i_step_b : i_step_a;
      due = 1'b0;
      moved = 1'b0;
      clamped = st_ff.acc;
      case (st_ff.state)
         ST_IDLE: begin
            nxt_st.state = ST_RUN;
         end
         ST_RUN: begin
            if (tick) begin
               // Elapsed time grows in task-interval steps
               nxt_st.elapsed_ms = st_ff.elapsed_ms + 16'(TASK_INTERVAL_MS);
               due = ({1'b0, st_ff.elapsed_ms} + 17'(TASK_INTERVAL_MS))
                     >= {1'b0, i_period_ms};
               nxt_st.dir = DIR_NONE;
               if (ctl_s[3]) begin
                  sum = 18'(i_preset);
                  moved = (i_preset != st_ff.acc);
               end else if (due && ctl_s[2]) begin
                  sum = 18'(st_ff.acc) + 18'(step);
                  nxt_st.dir = DIR_UP;
                  moved = 1'b1;
               end else if (due && ctl_s[1]) begin
                  sum = 18'(st_ff.acc) - 18'(step);
                  nxt_st.dir = DIR_DOWN;
                  moved = 1'b1;
               end
               // Saturate to plus or minus 32767 first, so the flags judge the value kept
               if (sum > 18'($signed(POS_LIMIT))) begin
                  sum = 18'($signed(POS_LIMIT));
               end else if (sum < 18'($signed(NEG_LIMIT))) begin
                  sum = 18'($signed(NEG_LIMIT));
               end
               // Clamp to the limits after the step
               if (sum > 18'(i_upper)) begin
                  clamped = i_upper;
                  nxt_st.hi = 1'b1;
                  nxt_st.lo = 1'b0;
               end else if (sum < 18'(i_lower)) begin
                  clamped = i_lower;
                  nxt_st.hi = 1'b0;
                  nxt_st.lo = 1'b1;
               end else begin
                  clamped = sum[15:0];
                  if (sum < 18'(i_upper) && sum > 18'(i_lower)) begin
                     nxt_st.hi = 1'b0;
                     nxt_st.lo = 1'b0;
                  end
               end
               if (clamped > $signed(POS_LIMIT)) begin
                  clamped = $signed(POS_LIMIT);
               end else if (clamped < $signed(NEG_LIMIT)) begin
                  clamped = $signed(NEG_LIMIT);
               end
               nxt_st.acc = clamped;
               if (clamped == st_ff.acc) begin
                  nxt_st.dir = DIR_NONE;
               end
               if (moved || due) begin
                  nxt_st.elapsed_ms = 16'h0000;
               end
            end
         end
         default: begin
            nxt_st.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_ff.state      <= ST_IDLE;
         st_ff.acc        <= ACC_RST;
         st_ff.dir        <= DIR_NONE;
         st_ff.hi         <= 1'b0;
         st_ff.lo         <= 1'b0;
         st_ff.elapsed_ms <= PERIOD_RST;
      end else if (i_ce) begin
         st_ff <= nxt_st;
      end
   end

   assign o_count         = st_ff.acc;
   assign o_dir           = st_ff.dir;
   assign o_at_high_limit = st_ff.hi;
   assign o_at_low_limit  = st_ff.lo;
endmodule

// ---- test/tudc_top_asserts.sv ----
/*
   Checker on the ports of tudc_top.
   Assumes a bind into every tudc_top instance.
*/
`timescale 1ns/10ps
module tudc_top_asserts
   import tudc_pkg::*;
#(
   parameter int TICK_CYC = TASK_TICK_CYC
) (
   input wire logic               i_clk_sys, i_sys_rst, i_ce, i_load, i_inc, i_dec, i_select,
   input wire logic signed [15:0] i_preset, i_upper, i_lower, i_step_a, i_step_b,
   input wire logic        [15:0] i_period_ms,
   input wire logic signed [15:0] o_count,
   input wire logic signed [1:0]  o_dir,
   input wire logic               o_at_high_limit, o_at_low_limit
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   property p_dir_code; o_dir != 2'h2; endproperty
   a_dir_code: assert property (p_dir_code) else $error("dir code illegal");
   property p_no_min; o_count != 16'h8000; endproperty
   a_no_min: assert property (p_no_min) else $error("count out of range");
   property p_excl; !(o_at_high_limit && o_at_low_limit); endproperty
   a_excl: assert property (p_excl) else $error("both limit flags set");
   property p_within; $changed(o_count) |-> o_count <= i_upper && o_count >= i_lower; endproperty
   a_within: assert property (p_within) else $error("count beyond limits");
   property p_between;
      $changed(o_count) && o_count < i_upper && o_count > i_lower
         |-> !o_at_high_limit && !o_at_low_limit;
   endproperty
   a_between: assert property (p_between) else $error("flag set inside limits");
   property p_up; $changed(o_count) && o_dir == DIR_UP |-> o_count > $past(o_count); endproperty
   a_up: assert property (p_up) else $error("up without rise");
   property p_down; $changed(o_count) && o_dir == DIR_DOWN |-> o_count < $past(o_count); endproperty
   a_down: assert property (p_down) else $error("down without fall");
   property p_idle_dir; $stable(o_count) && $changed(o_dir) |-> o_dir == DIR_NONE; endproperty
   a_idle_dir: assert property (p_idle_dir) else $error("dir moved without change");
   property p_load;
      (i_ce && i_load && i_preset <= i_upper && i_preset >= i_lower) [*8]
         |=> TICK_CYC > 4 || o_count == i_preset;
   endproperty
   a_load: assert property (p_load) else $error("load not applied");
   c_hi: cover property ($rose(o_at_high_limit));
   c_lo: cover property ($rose(o_at_low_limit));
   c_down: cover property ($changed(o_count) && o_dir == DIR_DOWN);
endmodule
bind tudc_top tudc_top_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.i_clk_sys, .i_sys_rst, .i_ce,
   .i_load, .i_inc, .i_dec, .i_select, .i_preset, .i_upper, .i_lower, .i_step_a, .i_step_b,
   .i_period_ms, .o_count, .o_dir, .o_at_high_limit, .o_at_low_limit);

// ---- test/timed_up_down_counter_bench.sv ----
/*
   Bench for tudc_top: load, steps, limits, saturation and period.
   Assumes a tick every 4 cycles and the checker bound in.
*/
`timescale 1ns/10ps
module timed_up_down_counter_bench import tudc_pkg::*;;
   logic clk = 0, rst = 1, ce = 1, load = 0, inc = 0, dec = 0, sel = 0, hi, lw;
   logic signed [15:0] pre = 16'h0000, up = 16'h03E8, lo = 16'hFC18, cnt;
   logic signed [15:0] sa = 16'h0005, sb = 16'h0007;
   logic        [15:0] per = 16'h0000;
   logic signed [1:0]  dir;
   int                 errors = 0, compares = 0, n;
   tudc_top #(.TICK_CYC(4)) uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce), .i_load(load),
      .i_inc(inc), .i_dec(dec), .i_select(sel), .i_preset(pre), .i_upper(up), .i_lower(lo),
      .i_step_a(sa), .i_step_b(sb), .i_period_ms(per), .o_count(cnt), .o_dir(dir),
      .o_at_high_limit(hi), .o_at_low_limit(lw));
   initial forever #10 clk = ~clk;
   task summarize;
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task cmp_cnt(input logic [15:0] a, e);
      compares++;
      if (a !== e) begin
         errors++;
         $display("[FAIL] %0t count %h exp %h", $time, a, e);
      end
   endtask
   task cmp_st(input logic [3:0] a, e);
      compares++;
      if (a !== e) begin
         errors++;
         $display("[FAIL] %0t state %h exp %h", $time, a, e);
      end
   endtask
   task cmp_cyc(input logic [15:0] a, e);
      compares++;
      if (a !== e) begin
         errors++;
         $display("[FAIL] %0t cycles %h exp %h", $time, a, e);
      end
   endtask
   task wait_chg;
      logic [15:0] old;
      old = cnt;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cnt === old && n < 200);
   endtask
   task idle(input logic [15:0] p, u, l, input logic ld);
      @(posedge clk);
      {pre, up, lo} <= {p, u, l};
      load <= ld;
      inc <= ld;
      dec <= 0;
      repeat (20) @(negedge clk);
   endtask
   task do_load(input logic [15:0] p, u, l);
      idle(p, u, l, 1);
      cmp_cnt(cnt, p);
      cmp_st({dir, hi, lw}, {DIR_NONE, 2'b00});
      idle(p, u, l, 0);
   endtask
   task run(input logic i, d, s, input logic [15:0] u, l, e, input logic [3:0] es);
      @(posedge clk);
      {inc, dec, sel, up, lo} <= {i, d, s, u, l};
      @(negedge clk);
      wait_chg;
      cmp_cnt(cnt, e);
      cmp_st({dir, hi, lw}, es);
      idle(pre, u, l, 0);
   endtask
   task period_run;
      @(posedge clk);
      per <= 16'h0050;
      inc <= 1;
      @(negedge clk);
      wait_chg;
      wait_chg;
      cmp_cyc(n[15:0], 16'h0010);
      cmp_cnt(cnt, 16'h800B);
      cmp_st({dir, hi, lw}, {DIR_UP, 2'b00});
   endtask
   task freeze_run;
      @(posedge clk);
      ce <= 0;
      repeat (40) @(negedge clk);
      cmp_cnt(cnt, 16'h800B);
      cmp_st({dir, hi, lw}, {DIR_UP, 2'b00});
      @(posedge clk);
      ce <= 1;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      @(negedge clk);
      cmp_cnt(cnt, ACC_RST);
      cmp_st({dir, hi, lw}, 4'h0);
      do_load(16'h0064, 16'h03E8, 16'hFC18);
      run(1, 0, 0, 16'h03E8, 16'hFC18, 16'h0069, {DIR_UP, 2'b00});
      run(0, 1, 1, 16'h03E8, 16'hFC18, 16'h0062, {DIR_DOWN, 2'b00});
      run(1, 0, 1, 16'h0064, 16'hFC18, 16'h0064, {DIR_UP, 2'b10});
      run(0, 1, 1, 16'h0064, 16'h005F, 16'h005F, {DIR_DOWN, 2'b01});
      cmp_st({dir, hi, lw}, {DIR_NONE, 2'b01});
      do_load(16'h8003, 16'h03E8, 16'h8000);
      run(0, 1, 0, 16'h03E8, 16'h8000, 16'h8001, {DIR_DOWN, 2'b00});
      period_run;
      freeze_run;
      summarize;
   end
   initial begin
      #50000;
      errors++;
      summarize;
   end
endmodule
